// File: hdl/psdf_pkg.sv
// Shared constants, types and register map of the PWM/SR controller
package psdf_pkg;

	// ==============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;  // Core clock period
	localparam int UPD_WIN_NS = 132;     // Edge update window
	localparam int TMR_RES_NS = 4;       // Conduction timer step
	// Window in cycles, rounded up
	localparam logic [15:0] UPD_WIN_CYC =
		16'((UPD_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Timer units that one core cycle stands for
	localparam logic [15:0] COND_STEP =
		16'(CLK_PERIOD_NS / TMR_RES_NS);

	// ==============================================================
	// Register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_EV12 = 8'h08;
	localparam logic [7:0] ADDR_EV34 = 8'h0c;
	localparam logic [7:0] ADDR_DETECT = 8'h10;
	localparam logic [7:0] ADDR_SRCFG = 8'h14;
	localparam logic [7:0] ADDR_BLANK = 8'h18;
	localparam logic [7:0] ADDR_TRUNC = 8'h1c;
	localparam logic [7:0] ADDR_COND = 8'h20;
	localparam logic [7:0] ADDR_STAT = 8'h24;
	localparam logic [7:0] ADDR_MASK = 8'h28;
	localparam logic [7:0] ADDR_SRADJ = 8'h2c;

	// ==============================================================
	// Field positions
	localparam int CTRL_W = 6;           // Stored control bits
	localparam int CTL_RESTART = 6;      // Write-only restart bit
	localparam int ST_PERIOD = 0;        // Period event
	localparam int ST_TRUNC = 1;         // Pulse truncated
	localparam int ST_CCL = 2;           // Current-limit fault
	localparam int ST_SEC = 3;           // Secondary latched off
	localparam int ST_SR0 = 4;           // Channel 0 measured
	localparam int ST_W = 6;             // Status width

	// ==============================================================
	// Reset values
	localparam logic [15:0] PERIOD_RST = 16'h0063;
	localparam logic [7:0] CCL_LIM_RST = 8'h0f;

	// Control bits, bit 0 is the lowest field
	typedef struct packed {
		logic reson;      // Resonant mode
		logic ccl_en;     // Current-limit truncation
		logic pcm_en;     // Peak-current truncation
		logic blank_pcm;  // Blanking feeds peak-current logic
		logic dto_en;     // Dead-time optimizer
		logic pwm_en;     // Module enable
	} psdf_ctrl_type;

	// Optimizer settings for one channel
	typedef struct packed {
		logic [7:0] blank;   // Detect blanking, cycles
		logic [7:0] len;     // Detect window length, cycles
		logic [7:0] target;  // Conduction target, timer units
		logic [7:0] step;    // Adjustment step, cycles
		logic [7:0] min;     // Lowest adjustment
		logic [7:0] max;     // Highest adjustment
	} psdf_sr_cfg_type;

	// Detection sequencer
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_BLANK = 3'b010,
		S_WIN = 3'b100
	} psdf_sr_state_type;

endpackage

// File: hdl/psdf_blank.sv
// Leading-edge blanking timer for one front end
module psdf_blank (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Pulse and blanking length
	input wire logic pulse,
	input wire logic [7:0] cyc,
	// Blanking active
	output logic blank
);
	import psdf_pkg::*;

	logic prev_q;       // Pulse one cycle ago
	logic [7:0] cnt_q;  // Remaining blanking cycles
	logic rise;         // Pulse rising edge

	assign rise = pulse & ~prev_q;
	assign blank = (rise && cyc != 8'h00) || cnt_q != 8'h00;

	// ==============================================================
	// Edge detect and countdown
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (ce) begin
			prev_q <= pulse;
			if (rise && cyc != 8'h00) begin
				cnt_q <= cyc - 8'h01;
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule // psdf_blank

// File: hdl/psdf_sr_chan.sv
// Conduction-time detector and turn-off adjuster for one SR channel
module psdf_sr_chan (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Control
	input wire logic en,
	input wire psdf_pkg::psdf_sr_cfg_type cfg,
	// Link
	input wire logic sr_pwm,
	input wire logic sense,
	// Results
	output logic [15:0] meas_q,
	output logic [7:0] adj_q,
	output logic done_q
);
	import psdf_pkg::*;

	psdf_sr_state_type st_q;  // Sequencer state
	logic prev_q;             // Output one cycle ago
	logic [7:0] tmr_q;        // Phase countdown
	logic [15:0] acc_q;       // Conduction accumulator
	logic win_end;            // Last window cycle
	logic [15:0] total;       // Final measured time
	logic [8:0] up;           // Delayed edge candidate
	logic [8:0] dn;           // Advanced edge candidate

	assign win_end = st_q == S_WIN && tmr_q <= 8'h01;
	assign total = acc_q + (sense ? COND_STEP : 16'h0000);
	assign up = {1'b0, adj_q} + {1'b0, cfg.step};
	assign dn = {1'b0, adj_q} - {1'b0, cfg.step};

	// ==============================================================
	// Detection sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			prev_q <= 1'b0;
			tmr_q <= 8'h00;
			acc_q <= 16'h0000;
		end else if (ce) begin
			prev_q <= sr_pwm;
			unique case (st_q)
				// Falling edge opens the window
				S_IDLE: if (en && prev_q && !sr_pwm) begin
					st_q <= S_BLANK;
					tmr_q <= cfg.blank;
					acc_q <= 16'h0000;
				end
				// Blanking before the window
				S_BLANK: if (tmr_q <= 8'h01) begin
					st_q <= S_WIN;
					tmr_q <= cfg.len;
				end else begin
					tmr_q <= tmr_q - 8'h01;
				end
				// Count conduction in timer units
				S_WIN: begin
					acc_q <= total;
					if (win_end) begin
						st_q <= S_IDLE;
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ==============================================================
	// Result capture and edge adjustment
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meas_q <= 16'h0000;
			adj_q <= 8'h00;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= win_end;
			if (!en) begin
				adj_q <= 8'h00;
			end else if (win_end) begin
				meas_q <= total;
				// Too long conduction delays the turn-off
				// Both limits clamp, adj may start outside them
				if (total > {8'h00, cfg.target}) begin
					adj_q <= (up > {1'b0, cfg.max}) ? cfg.max :
						(up < {1'b0, cfg.min}) ? cfg.min : up[7:0];
				end else begin
					adj_q <= (dn[8] || dn < {1'b0, cfg.min}) ? cfg.min :
						(dn > {1'b0, cfg.max}) ? cfg.max : dn[7:0];
				end
			end
		end
	end

	a_window_opens: assert property (
		@(posedge clk) disable iff (rst)
		(ce && en && st_q == S_IDLE && prev_q && !sr_pwm)
			|=> st_q == S_BLANK && tmr_q == $past(cfg.blank))
		else $error("detect window did not open");

	a_adj_bounds: assert property (
		@(posedge clk) disable iff (rst)
		(ce && en && win_end && $stable(cfg) && cfg.min <= cfg.max)
			|=> adj_q <= cfg.max && adj_q >= cfg.min)
		else $error("edge adjustment out of limits");
endmodule // psdf_sr_chan

// File: hdl/psdf_ctrl.sv
// PWM output stage with truncation, faults and SR dead-time optimizer
//
// Function
// - Accept two conduction senses from SR driver
// - Open detect window after each SR fall
// - Window set by blanking delay and length
// - Measure conduction with 4 ns timer
// - Measured time moves next SR turn-off
// - Truncation captures PWM counter value
// - Secondary output restarts without module re-enable
// - Edge update window of 132 ns rounds up to 2 cycles, 200 ns
// - Current-limit counter frozen during blanking
// - Peak-current blanking on every front end
// - No period interrupt while module disabled
// - No extended pulse on mode switch
// - Shutdown or current-limit fault drives all outputs low
// - Optimizer disabled after reset
module psdf_ctrl (
	// Clock, reset and clock enable
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Front-end trips and faults
	input wire logic PCM_TRIP,
	input wire logic CCL_TRIP,
	input wire logic FAULT_B,
	input wire logic SHUTDOWN,
	// SR driver conduction senses
	input wire logic CONDUCTION_SENSE_0,
	input wire logic CONDUCTION_SENSE_1,
	// PWM outputs
	output logic PWM_PRIMARY,
	output logic PWM_SECONDARY_OUTPUT,
	output logic SR_PWM_OUT_0,
	output logic SR_PWM_OUT_1,
	// Interrupt
	output logic IRQ
);
	import psdf_pkg::*;

	// ==============================================================
	// Span decode, used for every output
	function automatic logic in_span(input logic [15:0] c,
		input logic [15:0] lo, input logic [15:0] hi);
		in_span = c >= lo && c < hi;
	endfunction

	// ==============================================================
	// Registers and state
	psdf_ctrl_type ctrl_q;          // Control bits
	logic [15:0] period_q;          // Last count of the period, period is one cycle more
	logic [3:0][15:0] ev_sh_q;      // Edge values written
	logic [3:0][15:0] ev_q;         // Edge values in use
	psdf_sr_cfg_type cfg_q;         // Optimizer settings
	logic [7:0] blank_cyc_q;        // Front-end blanking
	logic [7:0] ccl_lim_q;          // Fault count limit
	logic [15:0] trunc_q;           // Captured counter
	logic [ST_W-1:0] status_q;      // Sticky events
	logic [ST_W-1:0] mask_q;        // Interrupt mask
	logic [15:0] cnt_q;             // PWM counter
	logic reson_q;                  // Mode in force
	logic cut_a_q;                  // Primary cut this period
	logic cut_b_q;                  // Secondary cut this period
	logic sec_fault_q;              // Secondary latched off
	logic [7:0] ccl_cnt_q;          // Current-limit count
	logic ccl_fault_q;              // Current-limit fault
	logic [31:0] rdata_d;           // Read mux

	// ==============================================================
	// Per-channel wiring
	logic [1:0] blk;                // Blanking per front end
	logic [1:0] pulse;              // Pulse per front end
	logic [1:0] sense;              // Conduction senses
	logic [1:0] sr_q;               // SR outputs
	logic [1:0] done;               // Measurement done
	logic [1:0][15:0] meas;         // Measured times
	logic [1:0][7:0] adj;           // Edge adjustments

	// ==============================================================
	// Combinational terms
	logic wrap;                     // Last cycle of period
	logic upd;                      // Inside update window
	logic sh;                       // Force all low
	logic [15:0] b_lo;              // Secondary rise
	logic [15:0] b_hi;              // Secondary fall
	logic pcm_a;                    // Peak trip, primary
	logic pcm_b;                    // Peak trip, secondary
	logic ccl_a;                    // Limit trip, primary
	logic ccl_b;                    // Limit trip, secondary
	logic hit;                      // Any truncation
	logic [15:0] off0;              // SR0 turn-off
	logic [15:0] off1;              // SR1 turn-off
	logic wr_ctrl;                  // Control write
	logic rd_stat;                  // Status read
	logic [ST_W-1:0] st_set;        // Status set terms

	assign pulse = {PWM_SECONDARY_OUTPUT, PWM_PRIMARY};
	assign sense = {CONDUCTION_SENSE_1, CONDUCTION_SENSE_0};
	assign wr_ctrl = WR && ADDR == ADDR_CTRL;
	assign rd_stat = RD && ADDR == ADDR_STAT;
	assign wrap = cnt_q >= period_q;
	assign upd = cnt_q < UPD_WIN_CYC;
	assign sh = SHUTDOWN || ccl_fault_q;

	// Resonant mode mirrors primary edges at half period
	assign b_lo = reson_q ? ev_q[0] + (period_q >> 1) : ev_q[2];
	assign b_hi = reson_q ? ev_q[1] + (period_q >> 1) : ev_q[3];

	// Limit trips honoured only outside blanking, peak trips too when blank_pcm is set
	assign pcm_a = ctrl_q.pcm_en && PCM_TRIP && PWM_PRIMARY &&
		!(blk[0] && ctrl_q.blank_pcm);
	assign pcm_b = ctrl_q.pcm_en && PCM_TRIP && PWM_SECONDARY_OUTPUT &&
		!(blk[1] && ctrl_q.blank_pcm);
	assign ccl_a = ctrl_q.ccl_en && CCL_TRIP && PWM_PRIMARY &&
		!blk[0];
	assign ccl_b = ctrl_q.ccl_en && CCL_TRIP &&
		PWM_SECONDARY_OUTPUT && !blk[1];
	assign hit = pcm_a || pcm_b || ccl_a || ccl_b;

	// Optimizer moves the SR turn-off edges
	assign off0 = ev_q[1] + (ctrl_q.dto_en ? {8'h00, adj[0]} :
		16'h0000);
	assign off1 = b_hi + (ctrl_q.dto_en ? {8'h00, adj[1]} :
		16'h0000);

	// ==============================================================
	// Blanking and SR channels
	generate
		for (genvar i = 0; i < 2; i++) begin : g_ch
			// Blanking timer on each front end
			psdf_blank u_blank (
				.clk(CORE_CLK),
				.rst(RST),
				.ce(CE),
				.pulse(pulse[i]),
				.cyc(blank_cyc_q),
				.blank(blk[i])
			);
			// Conduction measurement and adjuster
			psdf_sr_chan u_sr (
				.clk(CORE_CLK),
				.rst(RST),
				.ce(CE),
				.en(ctrl_q.dto_en),
				.cfg(cfg_q),
				.sr_pwm(sr_q[i]),
				.sense(sense[i]),
				.meas_q(meas[i]),
				.adj_q(adj[i]),
				.done_q(done[i])
			);
		end
	endgenerate

	// ==============================================================
	// Register writes
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= '0;
			period_q <= PERIOD_RST;
			ev_sh_q <= '0;
			cfg_q <= '0;
			blank_cyc_q <= 8'h00;
			ccl_lim_q <= CCL_LIM_RST;
			mask_q <= '0;
		end else if (CE && WR) begin
			unique case (ADDR)
				ADDR_CTRL: ctrl_q <= psdf_ctrl_type'(WDATA[CTRL_W-1:0]);
				ADDR_PERIOD: period_q <= WDATA[15:0];
				ADDR_EV12: ev_sh_q[1:0] <= WDATA;
				ADDR_EV34: ev_sh_q[3:2] <= WDATA;
				ADDR_DETECT: begin
					cfg_q.blank <= WDATA[7:0];
					cfg_q.len <= WDATA[15:8];
				end
				ADDR_SRCFG: begin
					cfg_q.target <= WDATA[7:0];
					cfg_q.step <= WDATA[15:8];
					cfg_q.min <= WDATA[23:16];
					cfg_q.max <= WDATA[31:24];
				end
				ADDR_BLANK: begin
					blank_cyc_q <= WDATA[7:0];
					ccl_lim_q <= WDATA[15:8];
				end
				ADDR_MASK: mask_q <= WDATA[ST_W-1:0];
				default: ;
			endcase
		end
	end

	// ==============================================================
	// Period counter, edge loading and mode switch
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cnt_q <= 16'h0000;
			ev_q <= '0;
			reson_q <= 1'b0;
		end else if (CE) begin
			if (!ctrl_q.pwm_en || wrap) begin
				cnt_q <= 16'h0000;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
			// Edges load only early in the period
			if (upd) begin
				ev_q <= ev_sh_q;
			end
			// Mode changes only at the period boundary or while disabled
			if (wrap || !ctrl_q.pwm_en) begin
				reson_q <= ctrl_q.reson;
			end
		end
	end

	// ==============================================================
	// Truncation capture and per-period cuts
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			trunc_q <= 16'h0000;
			cut_a_q <= 1'b0;
			cut_b_q <= 1'b0;
		end else if (CE) begin
			// Counter value held until next truncation
			if (hit) begin
				trunc_q <= cnt_q;
			end
			cut_a_q <= !wrap && (cut_a_q || pcm_a || ccl_a);
			cut_b_q <= !wrap && (cut_b_q || pcm_b || ccl_b);
		end
	end

	// ==============================================================
	// Fault latches
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sec_fault_q <= 1'b0;
			ccl_cnt_q <= 8'h00;
			ccl_fault_q <= 1'b0;
		end else if (CE) begin
			// Fault set wins over the restart bit
			if (FAULT_B) begin
				sec_fault_q <= 1'b1;
			end else if (wr_ctrl && WDATA[CTL_RESTART]) begin
				sec_fault_q <= 1'b0;
			end
			// Count only trips seen outside blanking
			if (!ctrl_q.pwm_en) begin
				ccl_cnt_q <= 8'h00;
				ccl_fault_q <= 1'b0;
			end else if (ccl_a || ccl_b) begin
				ccl_cnt_q <= ccl_cnt_q + 8'h01;
				if (ccl_cnt_q + 8'h01 >= ccl_lim_q) begin
					ccl_fault_q <= 1'b1;
				end
			end
		end
	end

	// ==============================================================
	// Outputs, all from flip-flops
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			PWM_PRIMARY <= 1'b0;
			PWM_SECONDARY_OUTPUT <= 1'b0;
			sr_q <= 2'b00;
		end else if (CE) begin
			PWM_PRIMARY <= ctrl_q.pwm_en && !sh && !cut_a_q &&
				!pcm_a && !ccl_a &&
				in_span(cnt_q, ev_q[0], ev_q[1]);
			PWM_SECONDARY_OUTPUT <= ctrl_q.pwm_en && !sh &&
				!sec_fault_q && !FAULT_B && !cut_b_q &&
				!pcm_b && !ccl_b && in_span(cnt_q, b_lo, b_hi);
			sr_q[0] <= ctrl_q.pwm_en && !sh &&
				in_span(cnt_q, ev_q[0], off0);
			sr_q[1] <= ctrl_q.pwm_en && !sh &&
				in_span(cnt_q, b_lo, off1);
		end
	end
	assign SR_PWM_OUT_0 = sr_q[0];
	assign SR_PWM_OUT_1 = sr_q[1];

	// ==============================================================
	// Status, cleared by reading it; a new event wins
	always_comb begin
		st_set = '0;
		st_set[ST_PERIOD] = wrap && ctrl_q.pwm_en;
		st_set[ST_TRUNC] = hit;
		st_set[ST_CCL] = (ccl_a || ccl_b) && ctrl_q.pwm_en &&
			ccl_cnt_q + 8'h01 >= ccl_lim_q;
		st_set[ST_SEC] = FAULT_B;
		st_set[ST_SR0 +: 2] = done;
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			status_q <= '0;
			IRQ <= 1'b0;
		end else if (CE) begin
			status_q <= (rd_stat ? '0 : status_q) | st_set;
			IRQ <= |(((rd_stat ? '0 : status_q) | st_set) & mask_q);
		end
	end

	// ==============================================================
	// Read port, data valid in the next cycle only
	always_comb begin
		unique case (ADDR)
			ADDR_CTRL: rdata_d = {26'h0, ctrl_q};
			ADDR_PERIOD: rdata_d = {16'h0, period_q};
			ADDR_EV12: rdata_d = ev_sh_q[1:0];
			ADDR_EV34: rdata_d = ev_sh_q[3:2];
			ADDR_DETECT: rdata_d = {16'h0, cfg_q.len, cfg_q.blank};
			ADDR_SRCFG: rdata_d = {cfg_q.max, cfg_q.min, cfg_q.step,
				cfg_q.target};
			ADDR_BLANK: rdata_d = {16'h0, ccl_lim_q, blank_cyc_q};
			ADDR_TRUNC: rdata_d = {16'h0, trunc_q};
			ADDR_COND: rdata_d = meas;
			ADDR_STAT: rdata_d = {26'h0, status_q};
			ADDR_MASK: rdata_d = {26'h0, mask_q};
			ADDR_SRADJ: rdata_d = {16'h0, adj};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (CE) begin
			RDATA <= RD ? rdata_d : 32'h0000_0000;
		end
	end

	// ==============================================================
	// Checks
	a_no_period_irq: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && !ctrl_q.pwm_en && !status_q[ST_PERIOD])
			|=> !status_q[ST_PERIOD])
		else $error("period event while disabled");

	a_shutdown_all_low: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && SHUTDOWN) |=> !PWM_PRIMARY && !PWM_SECONDARY_OUTPUT &&
			!SR_PWM_OUT_0 && !SR_PWM_OUT_1)
		else $error("output active during shutdown");

	a_trunc_capture: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && hit) |=> trunc_q == $past(cnt_q))
		else $error("truncation value not captured");

	a_trunc_holds: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		!(CE && hit) |=> $stable(trunc_q))
		else $error("truncation value changed");

	a_edge_freeze: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && cnt_q >= UPD_WIN_CYC) |=> $stable(ev_q))
		else $error("edges loaded outside window");

	a_ccl_blanked: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && ctrl_q.pwm_en && (blk[0] || !PWM_PRIMARY) &&
			(blk[1] || !PWM_SECONDARY_OUTPUT)) |=> $stable(ccl_cnt_q))
		else $error("limit counter moved in blanking");

	a_sec_latched: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(CE && sec_fault_q) |=> !PWM_SECONDARY_OUTPUT)
		else $error("secondary active while latched off");

	a_mode_boundary: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		!(CE && (wrap || !ctrl_q.pwm_en)) |=> $stable(reson_q))
		else $error("mode changed inside a period");
endmodule // psdf_ctrl

// File: verification/psdf_sr_drv_model.sv
// Behavioural model of the SR low-side driver conduction report
module psdf_sr_drv_model (
	// Clock
	input wire logic clk,
	// Gate from the controller, conduction length in cycles
	input wire logic gate,
	input wire logic [4:0] span,
	// Conduction report, driven at all times
	output logic sense
);
	timeunit 1ns;
	timeprecision 1ns;
	logic gate_q = 1'b0; // Gate one cycle ago
	int left = 0; // Conduction cycles still to report
	// Body diode conducts for span cycles after each gate fall
	always @(posedge clk) begin
		gate_q <= gate;
		if (gate_q && !gate)
			left <= span;
		else if (left > 0)
			left <= left - 1;
	end
	assign sense = (left > 0);
endmodule // psdf_sr_drv_model

// File: verification/psdf_ctrl_tb.sv
// Self-checking bench of the PWM/SR controller
module psdf_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import psdf_pkg::*;
	// ==========================================================
	// Signals
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic PCM_TRIP = 1'b0;
	logic CCL_TRIP = 1'b0;
	logic FAULT_B = 1'b0;
	logic SHUTDOWN = 1'b0;
	logic [4:0] span = 5'h00; // Conduction length for both models
	logic [31:0] RDATA, q, t;
	logic CONDUCTION_SENSE_0, CONDUCTION_SENSE_1, IRQ;
	logic PWM_PRIMARY, PWM_SECONDARY_OUTPUT, SR_PWM_OUT_0, SR_PWM_OUT_1;
	logic [3:0] outs; // All four PWM outputs
	int n_errors = 0, checks = 0, seed = 12653, len, tgt, hits;
	assign outs = {SR_PWM_OUT_1, SR_PWM_OUT_0, PWM_SECONDARY_OUTPUT,
		PWM_PRIMARY};
	always #50 CORE_CLK = ~CORE_CLK; // 10 MHz
	// ==========================================================
	// Design and driver models
	psdf_ctrl dut (.CORE_CLK(CORE_CLK), .RST(RST), .CE(1'b1),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.PCM_TRIP(PCM_TRIP), .CCL_TRIP(CCL_TRIP), .FAULT_B(FAULT_B),
		.SHUTDOWN(SHUTDOWN), .CONDUCTION_SENSE_0(CONDUCTION_SENSE_0),
		.CONDUCTION_SENSE_1(CONDUCTION_SENSE_1), .PWM_PRIMARY(PWM_PRIMARY),
		.PWM_SECONDARY_OUTPUT(PWM_SECONDARY_OUTPUT),
		.SR_PWM_OUT_0(SR_PWM_OUT_0), .SR_PWM_OUT_1(SR_PWM_OUT_1), .IRQ(IRQ));
	psdf_sr_drv_model u_drv0 (.clk(CORE_CLK), .gate(SR_PWM_OUT_0),
		.span(span), .sense(CONDUCTION_SENSE_0));
	psdf_sr_drv_model u_drv1 (.clk(CORE_CLK), .gate(SR_PWM_OUT_1),
		.span(span), .sense(CONDUCTION_SENSE_1));
	// ==========================================================
	// Tasks
	// Verdict and end of run
	task complete_run;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Compare one value
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One-cycle register write, one idle cycle after
	task wr(input logic [7:0] a, input logic [31:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	// One-cycle register read, data taken in the following cycle
	task rd(input logic [7:0] a);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 q = RDATA;
		@(posedge CORE_CLK);
	endtask
	// Count cycles in which any output of mask m is high
	task cnt(input logic [3:0] m, input int n);
		hits = 0;
		repeat (n) begin
			@(posedge CORE_CLK);
			#1 hits += int'((|(outs & m)) === 1'b1);
		end
		// Back on the edge before the next drive
		@(posedge CORE_CLK);
	endtask
	// ==========================================================
	// Watchdog against a hang
	initial begin
		repeat (6000) @(posedge CORE_CLK);
		n_errors++;
		$display("watchdog expired");
		complete_run();
	end
	// ==========================================================
	// Test sequence
	initial begin
		repeat (10) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(ADDR_CTRL);
		chk("ctrl", q, 32'h0);
		rd(ADDR_PERIOD);
		chk("period", q, 32'(PERIOD_RST));
		rd(ADDR_BLANK);
		chk("ccl_limit", 32'(q[15:8]), 32'(CCL_LIM_RST));
		wr(8'h30, 32'hffffffff);
		rd(8'h30);
		chk("unmapped", q, 32'h0);
		$display("reset test done");
		// Edges kept clear of the update window at counts 0 and 1
		wr(ADDR_PERIOD, 32'd40);
		wr(ADDR_EV12, {16'd10, 16'd3});
		wr(ADDR_EV34, {16'd25, 16'd15});
		len = 1 + int'($unsigned($random(seed)) % 8);
		tgt = 1 + int'($unsigned($random(seed)) % 24);
		wr(ADDR_DETECT, {16'h0, 8'(len), 8'd2});
		wr(ADDR_SRCFG, {8'd6, 8'd0, 8'd3, 8'(tgt)});
		span <= 5'd14;
		wr(ADDR_CTRL, 32'h3);
		repeat (250) @(posedge CORE_CLK);
		chk("irq_masked", IRQ, 32'h0);
		rd(ADDR_COND);
		chk("meas", q, {2{16'(len * int'(COND_STEP))}});
		rd(ADDR_SRADJ);
		chk("adj_delay", q, 32'h0606);
		cnt(4'b0100, 41);
		chk("sr0_width", hits, 13);
		span <= 5'd0;
		repeat (250) @(posedge CORE_CLK);
		rd(ADDR_COND);
		chk("meas_none", q, 32'h0);
		rd(ADDR_SRADJ);
		chk("adj_advance", q, 32'h0);
		$display("optimizer test done");
		rd(ADDR_STAT);
		wr(ADDR_MASK, 32'h1 << ST_PERIOD);
		repeat (45) @(posedge CORE_CLK);
		chk("irq", IRQ, 32'h1);
		rd(ADDR_STAT);
		chk("period_evt", q[ST_PERIOD], 32'h1);
		wr(ADDR_CTRL, 32'h0);
		// Zero period keeps the held counter at its wrap point
		wr(ADDR_PERIOD, 32'h0);
		rd(ADDR_STAT);
		repeat (90) @(posedge CORE_CLK);
		chk("irq_off", IRQ, 32'h0);
		rd(ADDR_STAT);
		chk("period_off", q[ST_PERIOD], 32'h0);
		wr(ADDR_PERIOD, 32'd40);
		$display("interrupt test done");
		wr(ADDR_BLANK, 32'h0f02);
		wr(ADDR_CTRL, 32'h0d);
		for (hits = 0; hits < 100 && PWM_PRIMARY !== 1'b1; hits++)
			@(posedge CORE_CLK);
		repeat (3) @(posedge CORE_CLK);
		PCM_TRIP <= 1'b1;
		@(posedge CORE_CLK);
		PCM_TRIP <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		rd(ADDR_TRUNC);
		t = q;
		chk("trunc_range", 32'(t >= 32'd3 && t < 32'd10), 32'h1);
		repeat (100) @(posedge CORE_CLK);
		rd(ADDR_TRUNC);
		chk("trunc_hold", q, t);
		rd(ADDR_STAT);
		chk("trunc_evt", q[ST_TRUNC], 32'h1);
		$display("truncation test done");
		// Blanking longer than the period hides every limit trip
		wr(ADDR_BLANK, 32'h01ff);
		repeat (45) @(posedge CORE_CLK);
		wr(ADDR_CTRL, 32'h11);
		CCL_TRIP <= 1'b1;
		repeat (100) @(posedge CORE_CLK);
		rd(ADDR_STAT);
		chk("ccl_blanked", q[ST_CCL], 32'h0);
		cnt(4'b0001, 41);
		chk("pri_width", hits, 7);
		// Without blanking the first trip reaches the limit
		wr(ADDR_BLANK, 32'h0100);
		repeat (300) @(posedge CORE_CLK);
		rd(ADDR_STAT);
		chk("ccl_fault", q[ST_CCL], 32'h1);
		cnt(4'b1111, 41);
		chk("ccl_all_low", hits, 0);
		CCL_TRIP <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
		$display("current limit test done");
		wr(ADDR_CTRL, 32'h1);
		FAULT_B <= 1'b1;
		@(posedge CORE_CLK);
		FAULT_B <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		cnt(4'b0010, 41);
		chk("sec_latched", hits, 0);
		wr(ADDR_CTRL, 32'h61);
		repeat (41) @(posedge CORE_CLK);
		cnt(4'b0010, 41);
		chk("sec_reson", hits, 7);
		wr(ADDR_CTRL, 32'h1);
		repeat (41) @(posedge CORE_CLK);
		cnt(4'b0010, 41);
		chk("sec_restart", hits, 10);
		SHUTDOWN <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		cnt(4'b1111, 41);
		chk("all_low", hits, 0);
		SHUTDOWN <= 1'b0;
		$display("fault test done");
		complete_run();
	end
endmodule // psdf_ctrl_tb
